// [verilog/tlf_pkg.sv]
package tlf_pkg;
    // Bus geometry
    localparam int          TLF_AW         = 8;
    localparam logic [1:0]  TLF_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  TLF_RESP_SLV   = 2'h2;
    // Register byte addresses
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STATUS     = 8'h04;
    localparam logic [7:0]  OFF_RES_INT    = 8'h08;
    localparam logic [7:0]  OFF_RES_EXT    = 8'h0c;
    localparam logic [7:0]  OFF_LIM_INT    = 8'h10;
    localparam logic [7:0]  OFF_LIM_EXT    = 8'h14;
    localparam logic [7:0]  OFF_QUEUE      = 8'h18;
    localparam logic [7:0]  OFF_DIODE      = 8'h1c;
    // Control fields
    localparam int          CT_MASK        = 7;
    localparam int          CT_RECD        = 4;
    localparam int          CT_BETA_EN     = 3;
    localparam int          CT_RANGE       = 2;
    localparam int          CT_FILT        = 8;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0008;
    // Status bit positions
    localparam int          ST_IHIGH       = 6;
    localparam int          ST_ILOW        = 5;
    localparam int          ST_EHIGH       = 4;
    localparam int          ST_ELOW        = 3;
    localparam int          ST_FAULT       = 2;
    // Limits: [7:0] high, [15:8] low, [23:16] critical
    localparam logic [31:0] LIM_RST        = 32'h0055_0055;
    // Queue: [7:0] hysteresis, [10:8] alert count, [14:12] critical count
    localparam logic [31:0] QUEUE_RST      = 32'h0000_110a;
    localparam logic [5:0]  IDEAL_NOM      = 6'h12;
    localparam int          IDEAL_SHIFT    = 9;
    // Series resistance correction, eighths of a degree per ohm times 8
    localparam logic [7:0]  REC_MAX_OHM    = 8'h64;
    localparam logic [13:0] REC_MUL        = 14'h002d;
    localparam int          REC_SHIFT      = 3;
    // Beta compensation settings, values arbitrary
    localparam logic [3:0]  BETA_OFF       = 4'h0;
    localparam logic [3:0]  BETA_DISCRETE  = 4'h7;
    localparam logic [3:0]  BETA_CPU       = 4'h8;
    // Result codes
    localparam logic [10:0] CODE_MAX_DEF   = 11'h3ff;
    localparam logic [10:0] CODE_MAX_EXT   = 11'h7ff;
    localparam logic [14:0] EXT_OFFSET     = 15'h0200;
    localparam logic [1:0]  FILT_OFF       = 2'h0;
    localparam logic [1:0]  FILT_L1        = 2'h1;
endpackage

// [verilog/tlf_core.sv]
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module tlf_core
    import tlf_pkg::*;
(
    input  wire  logic                 aclk,
    input  wire  logic                 aresetn,
    input  wire  logic [TLF_AW-1:0]    s_axi_awaddr,
    input  wire  logic                 s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire  logic [31:0]          s_axi_wdata,
    input  wire  logic [3:0]           s_axi_wstrb,
    input  wire  logic                 s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire  logic                 s_axi_bready,
    input  wire  logic [TLF_AW-1:0]    s_axi_araddr,
    input  wire  logic                 s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire  logic                 s_axi_rready,
    input  wire  logic                 meas_valid,
    input  wire  logic                 meas_ext,
    input  wire  logic signed [13:0]   meas_raw,
    input  wire  logic                 diode_open,
    input  wire  logic                 diode_vdd_short,
    input  wire  logic                 diode_gnd_short,
    input  wire  logic                 substrate_seen,
    input  wire  logic [7:0]           series_ohm,
    output logic [3:0]                 beta_sel,
    output logic                       alert_n,
    output logic                       crit_n
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0]         ctrl_q;
    logic [31:0]         lim_q [2];
    logic [31:0]         queue_q;
    logic [5:0]          ideal_q;
    logic [3:0]          beta_q;
    logic [10:0]         res_q [2];
    logic [7:0]          status_q;
    logic [1:0]          crit_act_q;
    logic [2:0]          acnt_q [2];
    logic [2:0]          ccnt_q [2];
    logic signed [13:0]  filt_q;
    logic                filt_seed_q;
    logic                aw_held_q;
    logic                w_held_q;
    logic [TLF_AW-1:0]   aw_addr_q;
    logic [31:0]         w_data_q;
    logic [3:0]          w_strb_q;
    logic                do_wr;
    logic                rd_take;
    logic [31:0]         rd_word;
    logic                rd_ok;
    logic                wr_ok;

    // Merge a write under its byte enables
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // Clamp a temperature in signed eighths into the selected range code
    function automatic logic [10:0] encode(input logic signed [13:0] t, input logic ext);
        logic signed [14:0] v;
        logic [10:0]        mx;
        v  = ext ? $signed({t[13], t}) + $signed(EXT_OFFSET) : $signed({t[13], t});
        mx = ext ? CODE_MAX_EXT : CODE_MAX_DEF;
        if (v < 0)
            return 11'h000;
        else if (v > $signed({4'h0, mx}))
            return mx;
        else
            return v[10:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Measurement datapath, internal channel index 0, external index 1
    logic                ch;
    logic [7:0]          ohm_c;
    logic [13:0]         corr;
    logic signed [13:0]  t1;
    logic signed [6:0]   idiff;
    logic signed [20:0]  prod;
    logic signed [13:0]  t2;
    logic signed [14:0]  fstep;
    logic signed [13:0]  t3;
    logic                fault;
    logic [10:0]         code;
    logic                hi_e;
    logic                lo_e;
    logic                cr_e;
    logic                cr_rel;
    logic [7:0]          rel_lim;
    logic [2:0]          acnt_d;
    logic [2:0]          ccnt_d;
    logic                qual_a;
    logic                qual_c;

    always_comb
    begin
        ch    = meas_ext;
        ohm_c = (series_ohm > REC_MAX_OHM) ? REC_MAX_OHM : series_ohm;
        corr  = 14'(({6'h00, ohm_c} * REC_MUL) >> REC_SHIFT);
        // Correction applies to the external diode path only
        t1    = (ch && !ctrl_q[CT_RECD]) ? meas_raw - $signed(corr) : meas_raw;
        idiff = $signed({1'b0, IDEAL_NOM}) - $signed({1'b0, ideal_q});
        prod  = t1 * idiff;
        // Gain trim scales with temperature, unlike a plain offset
        t2    = ch ? t1 + 14'(prod >>> IDEAL_SHIFT) : t1;
        fstep = ($signed({t2[13], t2}) - $signed({filt_q[13], filt_q}))
                >>> ((ctrl_q[CT_FILT +: 2] == FILT_L1) ? 1 : 2);
        if (!ch || ctrl_q[CT_FILT +: 2] == FILT_OFF || !filt_seed_q)
            t3 = t2;
        else
            t3 = filt_q + 14'(fstep);
        fault = ch && (diode_open || diode_vdd_short);
        // A short of the negative pin to ground is not a fault; it reads zero and raises the low event
        if (fault || (ch && diode_gnd_short))
            code = 11'h000;
        else
            code = encode(t3, ctrl_q[CT_RANGE]);
        hi_e    = !fault && code[10:3] > lim_q[ch][7:0];
        lo_e    = !fault && (code[10:3] < lim_q[ch][15:8] || (ch && diode_gnd_short));
        cr_e    = !fault && code[10:3] >= lim_q[ch][23:16];
        rel_lim = (lim_q[ch][23:16] >= queue_q[7:0]) ? lim_q[ch][23:16] - queue_q[7:0] : 8'h00;
        cr_rel  = code[10:3] < rel_lim;
        // Saturating consecutive counters; a programmed zero behaves as one
        acnt_d  = (hi_e || lo_e || fault) ? ((acnt_q[ch] == 3'h7) ? 3'h7 : acnt_q[ch] + 3'h1) : 3'h0;
        ccnt_d  = cr_e ? ((ccnt_q[ch] == 3'h7) ? 3'h7 : ccnt_q[ch] + 3'h1) : 3'h0;
        qual_a  = acnt_d != 3'h0 && acnt_d >= queue_q[10:8];
        qual_c  = ccnt_d != 3'h0 && ccnt_d >= queue_q[14:12];
    end

    // Result and counter state per channel, filter state for the external channel only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            res_q[0]    <= 11'h000;
            res_q[1]    <= 11'h000;
            acnt_q[0]   <= 3'h0;
            acnt_q[1]   <= 3'h0;
            ccnt_q[0]   <= 3'h0;
            ccnt_q[1]   <= 3'h0;
            filt_q      <= 14'h0000;
            filt_seed_q <= 1'b0;
        end
        else if (meas_valid)
        begin
            res_q[ch]  <= code;
            acnt_q[ch] <= acnt_d;
            ccnt_q[ch] <= ccnt_d;
            if (ch)
            begin
                filt_q      <= t3;
                filt_seed_q <= 1'b1;
            end
        end
    end

    // Beta setting follows the detected diode type on each external conversion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            beta_q <= BETA_OFF;
        else if (meas_valid && ch)
            beta_q <= !ctrl_q[CT_BETA_EN] ? BETA_OFF : (substrate_seen ? BETA_CPU : BETA_DISCRETE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a read that clears in the same cycle
    logic [7:0] st_set;
    always_comb
    begin
        st_set = 8'h00;
        if (meas_valid && qual_a)
        begin
            st_set[ch ? ST_EHIGH : ST_IHIGH] = hi_e;
            st_set[ch ? ST_ELOW : ST_ILOW]   = lo_e;
            st_set[ST_FAULT]                 = fault;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status_q <= 8'h00;
        else if (rd_take && s_axi_araddr == OFF_STATUS)
            status_q <= st_set;
        else
            status_q <= status_q | st_set;
    end

    // Critical latch per channel, released only below limit minus hysteresis
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            crit_act_q <= 2'b00;
        else if (meas_valid && qual_c)
            crit_act_q[ch] <= 1'b1;
        else if (meas_valid && cr_rel)
            crit_act_q[ch] <= 1'b0;
    end

    // Pins are active low and registered; mask gates the alert only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alert_n <= 1'b1;
            crit_n  <= 1'b1;
        end
        else
        begin
            alert_n <= !(|status_q[ST_IHIGH:ST_FAULT] && !ctrl_q[CT_MASK]);
            crit_n  <= !(|crit_act_q);
        end
    end

    assign beta_sel = beta_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data held independently, then committed
    assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= TLF_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            else if (do_wr || !aw_held_q)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            else if (do_wr || !w_held_q)
                s_axi_wready <= 1'b1;
            if (do_wr)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? TLF_RESP_OKAY : TLF_RESP_SLV;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign wr_ok = aw_addr_q == OFF_CTRL || aw_addr_q == OFF_LIM_INT || aw_addr_q == OFF_LIM_EXT
                || aw_addr_q == OFF_QUEUE || aw_addr_q == OFF_DIODE;

    // Writable registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q   <= CTRL_RST;
            lim_q[0] <= LIM_RST;
            lim_q[1] <= LIM_RST;
            queue_q  <= QUEUE_RST;
            ideal_q  <= IDEAL_NOM;
        end
        else if (do_wr)
        begin
            case (aw_addr_q)
                OFF_CTRL:    ctrl_q   <= wmerge(ctrl_q, w_data_q, w_strb_q);
                OFF_LIM_INT: lim_q[0] <= wmerge(lim_q[0], w_data_q, w_strb_q);
                OFF_LIM_EXT: lim_q[1] <= wmerge(lim_q[1], w_data_q, w_strb_q);
                OFF_QUEUE:   queue_q  <= wmerge(queue_q, w_data_q, w_strb_q);
                OFF_DIODE:   if (w_strb_q[0]) ideal_q <= w_data_q[5:0];
                default:     ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one outstanding read, answered on the cycle after accept
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFF_CTRL:    rd_word = {22'h0, ctrl_q[9:8], ctrl_q[7], 2'h0, ctrl_q[4:2], 2'h0};
            OFF_STATUS:  rd_word = {24'h0, status_q[7:2], crit_act_q[1], crit_act_q[0]};
            OFF_RES_INT: rd_word = {16'h0, res_q[0], 5'h00};
            OFF_RES_EXT: rd_word = {16'h0, res_q[1], 5'h00};
            OFF_LIM_INT: rd_word = {8'h0, lim_q[0][23:0]};
            OFF_LIM_EXT: rd_word = {8'h0, lim_q[1][23:0]};
            OFF_QUEUE:   rd_word = {17'h0, queue_q[14:12], 1'b0, queue_q[10:8], queue_q[7:0]};
            OFF_DIODE:   rd_word = {20'h0, beta_q, 2'h0, ideal_q};
            default:
            begin
                rd_word = 32'h0000_0000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= TLF_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? TLF_RESP_OKAY : TLF_RESP_SLV;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_crit_pin_low:
        assert property (@(posedge aclk) disable iff (!aresetn) |crit_act_q |=> !crit_n)
        else $error("critical output not asserted");
    chk_mask_alert_off:
        assert property (@(posedge aclk) disable iff (!aresetn) ctrl_q[CT_MASK] |=> alert_n)
        else $error("alert asserted while masked");
    chk_fault_zero_result:
        assert property (@(posedge aclk) disable iff (!aresetn)
            meas_valid && meas_ext && (diode_open || diode_vdd_short) |=> res_q[1] == 11'h000)
        else $error("fault result not zero");
    chk_gnd_short_low:
        assert property (@(posedge aclk) disable iff (!aresetn)
            meas_valid && meas_ext && diode_gnd_short && qual_a && !diode_open && !diode_vdd_short
            |=> res_q[1] == 11'h000 && status_q[ST_ELOW])
        else $error("ground short not reported low");
    chk_reset_filter_off:
        assert property (@(posedge aclk) !aresetn |=> ctrl_q[CT_FILT +: 2] == FILT_OFF && !ctrl_q[CT_RANGE])
        else $error("filter or range not default after reset");
    chk_default_clamp:
        assert property (@(posedge aclk) disable iff (!aresetn)
            meas_valid && !meas_ext && !ctrl_q[CT_RANGE] |=> res_q[0] <= CODE_MAX_DEF)
        else $error("default range code exceeds clamp");
    chk_fault_skip_low:
        assert property (@(posedge aclk) disable iff (!aresetn)
            meas_valid && meas_ext && diode_open && !status_q[ST_ELOW] |=> !status_q[ST_ELOW])
        else $error("low flag set on a faulted diode");
    chk_queue_gate:
        assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(status_q[ST_IHIGH]) |-> acnt_q[0] >= queue_q[10:8] && acnt_q[0] != 3'h0)
        else $error("alert flag before consecutive count");
    chk_crit_hold:
        assert property (@(posedge aclk) disable iff (!aresetn)
            crit_act_q[0] && !(meas_valid && !meas_ext) |=> crit_act_q[0])
        else $error("critical latch dropped without a measurement");

endmodule // tlf_core

// [tb/tlf_host_model.sv]
`timescale 1ns/10ps
module tlf_host_model
    import tlf_pkg::*;
(
    input  wire logic          aclk,
    output logic [TLF_AW-1:0]  s_axi_awaddr,
    output logic               s_axi_awvalid,
    input  wire logic          s_axi_awready,
    output logic [31:0]        s_axi_wdata,
    output logic [3:0]         s_axi_wstrb,
    output logic               s_axi_wvalid,
    input  wire logic          s_axi_wready,
    input  wire logic [1:0]    s_axi_bresp,
    input  wire logic          s_axi_bvalid,
    output logic               s_axi_bready,
    output logic [TLF_AW-1:0]  s_axi_araddr,
    output logic               s_axi_arvalid,
    input  wire logic          s_axi_arready,
    input  wire logic [31:0]   s_axi_rdata,
    input  wire logic [1:0]    s_axi_rresp,
    input  wire logic          s_axi_rvalid,
    output logic               s_axi_rready,
    output logic               hung
);
    // Idle bus from time zero
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end
    // Ideality is never rewritten while beta compensation runs
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 7'h7f};
        for (n = 0; n < 99 && !s_axi_bvalid; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 99) hung = 1'b1;
    endtask
    // Read address is held until arready is seen and rready until rvalid is sampled; the bench bound cuts a hang
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (n = 0; n < 99 && !s_axi_rvalid; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        if (n == 99) hung = 1'b1;
    endtask
endmodule // tlf_host_model

// [tb/tb_temp_result_limit_fault_logic.sv]
`timescale 1ns/10ps
module tb_temp_result_limit_fault_logic
    import tlf_pkg::*;
;
    logic [TLF_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, beta_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, hung;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, alert_n, crit_n;
    logic aclk = 1'b0, aresetn = 1'b0, meas_valid = 1'b0, meas_ext = 1'b0, diode_open = 1'b0;
    logic diode_vdd_short = 1'b0, diode_gnd_short = 1'b0, substrate_seen = 1'b0;
    logic signed [13:0] meas_raw = '0;
    logic [7:0] series_ohm = '0;
    int err_count = 0, checks_done = 0, seed = 71658, i, t, raw;
    localparam int corner [8] = '{-513, -512, -1, 0, 1023, 1024, 1535, 1536};
    localparam int fc [4] = '{'h108, 'h108, 'h208, 'h8};
    localparam int fr [4] = '{800, 0, 0, 123};
    localparam int fe [4] = '{800, 400, 300, 123};
    tlf_core tlf_core_i (.*);
    tlf_host_model tlf_host_model_i (.*);
    // 25 MHz clock
    always #20 aclk = ~aclk;
    // A stuck handshake ends the run
    always @(posedge hung)
    begin
        err_count++;
        report_and_stop();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One conversion; f is open, supply short, ground short, substrate
    task automatic meas(input logic e, input int v, input logic [3:0] f, input logic [7:0] ohm);
        @(posedge aclk);
        {meas_ext, diode_open, diode_vdd_short, diode_gnd_short, substrate_seen} <= {e, f};
        meas_raw <= 14'(v);
        series_ohm <= ohm;
        meas_valid <= 1'b1;
        @(posedge aclk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        tlf_host_model_i.rd(a, d, r);
        chk(d, exp);
    endtask
    // Clamped result word; the offset range shifts by 64 degrees
    function automatic logic [31:0] word(input int v, input bit x);
        int c, lim;
        lim = x ? int'(CODE_MAX_EXT) : int'(CODE_MAX_DEF);
        c = x ? v + int'(EXT_OFFSET) : v;
        c = c < 0 ? 0 : (c > lim ? lim : c);
        return {16'h0000, c[10:0], 5'h00};
    endfunction
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({alert_n, crit_n, beta_sel}, 6'h30);
        rdc(OFF_CTRL, CTRL_RST);
        rdc(OFF_LIM_EXT, LIM_RST);
        rdc(OFF_QUEUE, QUEUE_RST);
        rdc(OFF_DIODE, {26'h0, IDEAL_NOM});
        tlf_host_model_i.wr(8'h20, 32'h1, r);
        chk(r, TLF_RESP_SLV);
        rdc(8'h20, 32'h0);
        $display("test reset and bus done");
        for (i = 0; i < 4; i++)
        begin
            tlf_host_model_i.wr(OFF_CTRL, fc[i], r);
            meas(1'b1, fr[i], 4'h0, 8'h00);
            rdc(OFF_RES_EXT, word(fe[i], 0));
        end
        meas(1'b1, 1000, 4'h1, 8'h08);
        rdc(OFF_RES_EXT, word(955, 0));
        chk(beta_sel, BETA_CPU);
        meas(1'b1, 1000, 4'h0, 8'hc8);
        rdc(OFF_RES_EXT, word(438, 0));
        chk(beta_sel, BETA_DISCRETE);
        $display("test filter and corrections done");
        for (i = 0; i < 4; i++)
        begin
            tlf_host_model_i.rd(OFF_STATUS, d, r);
            meas(1'b1, i == 3 ? 400 : 1000, 4'h8 >> i, 8'h00);
            rdc(OFF_RES_EXT, word(i == 3 ? 400 : 0, 0));
            rdc(OFF_STATUS, i == 3 ? 32'h0 : (i == 2 ? 32'h8 : 32'h4));
        end
        $display("test diode faults done");
        for (t = 0; t < 2; t++)
        begin
            tlf_host_model_i.wr(OFF_CTRL, t ? 32'h0c : 32'h08, r);
            for (i = 0; i < 20; i++)
            begin
                raw = i < 8 ? corner[i] : $random(seed) % 1400 + 300;
                meas(1'b0, raw, 4'h0, 8'h00);
                rdc(OFF_RES_INT, word(raw, t[0]));
            end
        end
        $display("test range coding done");
        tlf_host_model_i.wr(OFF_CTRL, 32'h08, r);
        tlf_host_model_i.wr(OFF_QUEUE, 32'h130a, r);
        meas(1'b0, 200, 4'h0, 8'h00);
        tlf_host_model_i.rd(OFF_STATUS, d, r);
        repeat (2) @(posedge aclk);
        chk({alert_n, crit_n}, 2'h3);
        for (i = 0; i < 3; i++)
        begin
            meas(1'b0, 768, 4'h0, 8'h00);
            chk({alert_n, crit_n}, i == 2 ? 2'h0 : 2'h2);
        end
        tlf_host_model_i.wr(OFF_CTRL, 32'h88, r);
        tlf_host_model_i.rd(OFF_STATUS, d, r);
        meas(1'b0, 768, 4'h0, 8'h00);
        tlf_host_model_i.rd(OFF_STATUS, d, r);
        chk({alert_n, crit_n, d[ST_IHIGH]}, 3'h5);
        meas(1'b0, 640, 4'h0, 8'h00);
        chk(crit_n, 1'b0);
        meas(1'b0, 592, 4'h0, 8'h00);
        chk(crit_n, 1'b1);
        $display("test alert queue done");
        report_and_stop();
    end
endmodule // tb_temp_result_limit_fault_logic
